// ===== verilog/coa_operand_addr.sv
// operand addressing block of the 8-bit core, reached over AHB-Lite.
// assumes a single slave with zero wait states and word-only transfers.
// What this block does
// - keep pc high byte, reset zero
// - keep pc low byte, reset zero
// - immediate source: operand is value, two bytes
// - immediate arithmetic pairs with a or x
// - direct source: operand is address, two bytes
// - indexed source: operand plus index, two bytes
// - direct destination from a or x, two bytes
// - indexed destination takes accumulator as source
// - direct destination, immediate source, three bytes
// - indexed destination, immediate source, three bytes
// - register space access instead of ram
// - destination moves leave accumulator unchanged
// - bank bit picks one of two banks
// - index register supplies the indexed offset
//
// Register access over AHB-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module coa_operand_addr
  import coa_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [7:0] addr_out,
  output logic addr_reg_space,
  output logic addr_bank,
  output logic addr_write,
  output logic addr_strobe,
  output logic bank_select_bit,
  output logic [7:0] pc_high_byte,
  output logic [7:0] pc_low_byte
);

  // whole state of the block
  typedef struct packed {
    logic ap_valid; // pending data phase
    logic ap_write; // pending phase is a write
    logic [7:0] ap_addr; // pending byte address
    logic [31:0] hrdata; // read data for the bus
    logic hreadyout; // always ready
    logic hresp; // always okay
    coa_mode_t mode; // last decoded mode
    logic reg_sp; // register space selected
    coa_tgt_t tgt; // result target
    logic arith; // arithmetic opcode
    logic [7:0] op1; // first operand byte
    logic [7:0] op2; // second operand byte
    logic [7:0] acc; // accumulator
    logic [7:0] idx; // index register
    logic [7:0] flags; // flag register
    logic [7:0] sp; // stack pointer
    logic [7:0] pc_high; // program counter high byte
    logic [7:0] pc_low; // program counter low byte
    logic [7:0] eff_addr; // effective address
    logic eff_valid; // address in use
    logic eff_reg; // register space
    logic eff_bank; // bank of that access
    logic eff_write; // result is stored there
    logic [1:0] ilen; // instruction length
    coa_opnd_t src; // data source
    logic [7:0] imm; // immediate value
    coa_opnd_t opnd2; // second arithmetic operand
    logic strobe; // one-cycle access pulse
    logic fired; // decode took place last edge
  } coa_state_t;

  coa_state_t s; // registered state
  coa_state_t n; // next state
  logic [7:0] ag_addr; // address former result
  logic ag_valid; // address former: access needed
  logic ag_dest; // address former: destination mode
  coa_mode_t dec_mode; // mode carried by a control write
  coa_tgt_t dec_tgt; // target carried by a control write
  logic dec_arith; // arithmetic bit of a control write

  assign dec_mode = coa_mode_t'(hwdata[CTRL_MODE_LSB +: 3]);
  assign dec_tgt = coa_tgt_t'(hwdata[CTRL_TGT_LSB +: 2]);
  assign dec_arith = hwdata[CTRL_ARITH_BIT];

  // fed every cycle; only looked at when a control write lands
  coa_addr_gen u_addr_gen (
    .mode(dec_mode),
    .op1(s.op1),
    .index(s.idx),
    .addr(ag_addr),
    .valid(ag_valid),
    .dest(ag_dest)
  );

  // register read view of a given state
  function automatic logic [31:0] rd_mux(input coa_state_t st,
                                         input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      OFS_CTRL:
        d = {25'h0, st.arith, st.tgt, st.reg_sp, st.mode};
      OFS_OPND: d = {16'h0, st.op2, st.op1};
      OFS_CORE: d = {st.sp, st.flags, st.idx, st.acc};
      OFS_PC: d = {16'h0, st.pc_high, st.pc_low};
      OFS_RESULT:
        d = {6'h0, st.opnd2, st.imm, st.src, st.ilen, st.eff_write,
             st.eff_bank, st.eff_reg, st.eff_valid, st.eff_addr};
      // unmapped offsets read zero
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  // bus handling and decode in one pass
  always_comb begin
    n = s;
    n.strobe = 1'b0;
    n.fired = 1'b0;
    // data phase of a write: the word lands now
    if (s.ap_valid && s.ap_write) begin
      case (s.ap_addr)
        OFS_OPND: begin
          n.op1 = hwdata[7:0];
          n.op2 = hwdata[15:8];
        end
        OFS_CORE: begin
          n.acc = hwdata[7:0];
          n.idx = hwdata[15:8];
          n.flags = hwdata[23:16] & FLAGS_MASK;
          n.sp = hwdata[31:24];
        end
        OFS_CTRL: begin
          // a control write is one instruction decode
          n.fired = 1'b1;
          n.mode = dec_mode;
          n.reg_sp = hwdata[CTRL_REGSP_BIT];
          n.tgt = dec_tgt;
          n.arith = dec_arith;
          n.ilen = coa_mode_len(dec_mode);
          // pc moves past the whole instruction
          {n.pc_high, n.pc_low} = {s.pc_high, s.pc_low}
            + {14'h0, coa_mode_len(dec_mode)};
          n.eff_addr = ag_addr;
          n.eff_valid = ag_valid;
          n.eff_write = ag_dest;
          n.eff_reg = hwdata[CTRL_REGSP_BIT];
          n.eff_bank = s.flags[FLAG_BANK_BIT];
          n.strobe = ag_valid;
          n.imm = s.op1;
          n.src = OPND_NONE;
          n.opnd2 = OPND_NONE;
          unique case (dec_mode)
            MODE_SRC_IMM: begin
              // a plain move loads the target right here
              if (!dec_arith) begin
                unique case (dec_tgt)
                  TGT_A: n.acc = s.op1;
                  TGT_F: n.flags = s.op1 & FLAGS_MASK;
                  TGT_SP: n.sp = s.op1;
                  TGT_X: n.idx = s.op1;
                endcase
              end else if (dec_tgt == TGT_X) begin
                n.opnd2 = OPND_IDX;
              end else if (dec_tgt == TGT_A) begin
                n.opnd2 = OPND_ACC;
              end
            end
            MODE_SRC_DIR, MODE_SRC_IDX: begin
              // memory data feeds a or x
              n.src = OPND_MEM;
              if (dec_arith) begin
                n.opnd2 = (dec_tgt == TGT_X) ? OPND_IDX : OPND_ACC;
              end
            end
            MODE_DST_DIR: begin
              n.src = (dec_tgt == TGT_X) ? OPND_IDX : OPND_ACC;
              if (dec_arith) begin
                n.opnd2 = OPND_MEM;
              end
            end
            MODE_DST_IDX: begin
              n.src = OPND_ACC;
              if (dec_arith) begin
                n.opnd2 = OPND_MEM;
              end
            end
            MODE_DST_DIR_IMM, MODE_DST_IDX_IMM: begin
              // source is the second operand byte
              n.imm = s.op2;
              if (dec_arith) begin
                n.opnd2 = OPND_MEM;
              end
            end
            // reserved code decodes to no access
            MODE_RSVD: n.src = OPND_NONE;
          endcase
          // destination modes never write the accumulator
        end
        default: ;
      endcase
    end
    // address phase: accepted when selected, non-idle and the bus is ready
    n.ap_valid = hsel && htrans[1] && hready;
    n.ap_write = hwrite;
    n.ap_addr = haddr[7:0];
    // read view taken after this cycle's write, so no stale data
    n.hrdata = (n.ap_valid && !hwrite) ? rd_mux(n, haddr[7:0])
                                       : 32'h0000_0000;
    n.hreadyout = 1'b1;
    n.hresp = 1'b0;
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.hreadyout <= 1'b1;
      s.flags <= FLAGS_RESET;
      s.pc_high <= PC_RESET;
      s.pc_low <= PC_RESET;
      s.acc <= CORE_RESET;
      s.idx <= CORE_RESET;
      s.sp <= CORE_RESET;
      s.mode <= MODE_RSVD;
    end else begin
      s <= n;
    end
  end

  // every output straight from the state register
  assign hrdata = s.hrdata;
  assign hreadyout = s.hreadyout;
  assign hresp = s.hresp;
  assign addr_out = s.eff_addr;
  assign addr_reg_space = s.eff_reg;
  assign addr_bank = s.eff_bank;
  assign addr_write = s.eff_write;
  assign addr_strobe = s.strobe;
  assign bank_select_bit = s.flags[FLAG_BANK_BIT];
  assign pc_high_byte = s.pc_high;
  assign pc_low_byte = s.pc_low;

  // checks on the decode and the registers
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_fire;
    s.fired;
  endsequence

  sequence s_pc_read;
    s.ap_valid && !s.ap_write && s.ap_addr == OFS_PC;
  endsequence

  property p_pc_reset;
    $past(rst) |-> s.pc_high == 8'h00 && s.pc_low == 8'h00;
  endproperty
  a_pc_reset: assert property (p_pc_reset)
    else $error("pc not zero after reset");

  property p_pc_step;
    s_fire |-> {s.pc_high, s.pc_low} ==
      $past({s.pc_high, s.pc_low}) + {14'h0, s.ilen};
  endproperty
  a_pc_step: assert property (p_pc_step)
    else $error("pc did not advance by instruction length");

  property p_pc_read;
    (hsel && htrans[1] && hready && !hwrite && haddr[7:0] == OFS_PC)
      ##1 s_pc_read |-> hrdata[15:0] == {s.pc_high, s.pc_low};
  endproperty
  a_pc_read: assert property (p_pc_read)
    else $error("pc read data wrong");

  property p_len_two;
    s_fire ##0 (s.mode inside {MODE_SRC_IMM, MODE_SRC_DIR, MODE_SRC_IDX,
                               MODE_DST_DIR, MODE_DST_IDX})
      |-> s.ilen == 2'h2;
  endproperty
  a_len_two: assert property (p_len_two)
    else $error("two byte mode has wrong length");

  property p_len_three;
    s_fire ##0 (s.mode inside {MODE_DST_DIR_IMM, MODE_DST_IDX_IMM})
      |-> s.ilen == 2'h3 && s.imm == s.op2;
  endproperty
  a_len_three: assert property (p_len_three)
    else $error("three byte mode wrong");

  property p_idx_sum;
    s_fire ##0 (s.mode inside {MODE_SRC_IDX, MODE_DST_IDX,
                               MODE_DST_IDX_IMM})
      |-> s.eff_addr == 8'((9'(s.op1) + 9'($past(s.idx)))) && s.strobe;
  endproperty
  a_idx_sum: assert property (p_idx_sum)
    else $error("indexed address wrong");

  property p_dir_addr;
    s_fire ##0 (s.mode inside {MODE_SRC_DIR, MODE_DST_DIR,
                               MODE_DST_DIR_IMM})
      |-> s.eff_addr == s.op1 && s.strobe;
  endproperty
  a_dir_addr: assert property (p_dir_addr)
    else $error("direct address wrong");

  property p_acc_keep;
    s_fire ##0 s.eff_write |-> s.acc == $past(s.acc);
  endproperty
  a_acc_keep: assert property (p_acc_keep)
    else $error("accumulator changed by destination mode");

  property p_imm_load;
    s_fire ##0 (s.mode == MODE_SRC_IMM && !s.arith && s.tgt == TGT_A)
      |-> s.acc == s.op1 && !s.strobe;
  endproperty
  a_imm_load: assert property (p_imm_load)
    else $error("immediate move did not load accumulator");

  property p_bank;
    s.strobe |-> s.eff_bank == $past(s.flags[FLAG_BANK_BIT]) &&
      s.eff_reg == s.reg_sp;
  endproperty
  a_bank: assert property (p_bank)
    else $error("bank or space select wrong");

  property p_dst_opnd;
    s_fire ##0 (s.arith && s.mode == MODE_DST_DIR)
      |-> s.opnd2 == OPND_MEM && s.eff_write;
  endproperty
  a_dst_opnd: assert property (p_dst_opnd)
    else $error("destination arithmetic operand wrong");

endmodule // coa_operand_addr
`default_nettype wire

// ===== verilog/coa_pkg.sv
// operand addressing package: register map, field layout, reset values,
// mode codes and the shared address arithmetic.
// assumes one 250 MHz core clock and a 32-bit AHB-Lite register bus.
package coa_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_OPND = 8'h04;
  localparam logic [7:0] OFS_CORE = 8'h08;
  localparam logic [7:0] OFS_PC = 8'h0C;
  localparam logic [7:0] OFS_RESULT = 8'h10;

  // control word field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_REGSP_BIT = 3;
  localparam int CTRL_TGT_LSB = 4;
  localparam int CTRL_ARITH_BIT = 6;

  // flag register: bank select position and writable bits
  localparam int FLAG_BANK_BIT = 4;
  localparam logic [7:0] FLAGS_MASK = 8'h1F;

  // reset values
  localparam logic [7:0] PC_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h02;
  localparam logic [7:0] CORE_RESET = 8'h00;

  // instruction lengths in bytes
  localparam logic [1:0] LEN_NONE = 2'h0;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  // addressing modes
  typedef enum logic [2:0] {
    MODE_SRC_IMM = 3'b000,
    MODE_SRC_DIR = 3'b001,
    MODE_SRC_IDX = 3'b010,
    MODE_DST_DIR = 3'b011,
    MODE_DST_IDX = 3'b100,
    MODE_DST_DIR_IMM = 3'b101,
    MODE_DST_IDX_IMM = 3'b110,
    MODE_RSVD = 3'b111
  } coa_mode_t;

  // result target picked by the opcode
  typedef enum logic [1:0] {
    TGT_A = 2'b00,
    TGT_F = 2'b01,
    TGT_SP = 2'b10,
    TGT_X = 2'b11
  } coa_tgt_t;

  // where an operand comes from
  typedef enum logic [1:0] {
    OPND_NONE = 2'b00,
    OPND_ACC = 2'b01,
    OPND_IDX = 2'b10,
    OPND_MEM = 2'b11
  } coa_opnd_t;

  // operand byte plus index, carry dropped
  function automatic logic [7:0] coa_idx_sum(input logic [7:0] a,
                                             input logic [7:0] b);
    logic [8:0] full;
    full = {1'b0, a} + {1'b0, b};
    return full[7:0];
  endfunction

  // instruction length per mode
  function automatic logic [1:0] coa_mode_len(input coa_mode_t m);
    logic [1:0] len;
    unique case (m)
      MODE_DST_DIR_IMM, MODE_DST_IDX_IMM: len = LEN_THREE;
      MODE_RSVD: len = LEN_NONE;
      default: len = LEN_TWO;
    endcase
    return len;
  endfunction

endpackage

// ===== verilog/coa_addr_gen.sv
// effective address former for one decoded addressing mode.
// purely combinational; the caller registers what it needs.
`timescale 1ns/1ns
`default_nettype none
module coa_addr_gen
  import coa_pkg::*;
(
  input wire coa_mode_t mode,
  input wire logic [7:0] op1,
  input wire logic [7:0] index,
  output logic [7:0] addr,
  output logic valid,
  output logic dest
);

  // direct modes take the byte, indexed ones add the index register
  always_comb begin
    addr = 8'h00;
    valid = 1'b1;
    dest = 1'b0;
    unique case (mode)
      // immediate source touches no memory
      MODE_SRC_IMM: valid = 1'b0;
      MODE_SRC_DIR: addr = op1;
      MODE_SRC_IDX: addr = coa_idx_sum(op1, index);
      MODE_DST_DIR, MODE_DST_DIR_IMM: begin
        addr = op1;
        dest = 1'b1;
      end
      MODE_DST_IDX, MODE_DST_IDX_IMM: begin
        addr = coa_idx_sum(op1, index);
        dest = 1'b1;
      end
      // reserved code: no access at all
      MODE_RSVD: valid = 1'b0;
    endcase
  end

endmodule // coa_addr_gen
`default_nettype wire

// ===== tb/coa_mem_model.sv
// far-side model: data ram plus two register banks behind the decoder.
// assumes one registered strobe per decode that needs memory.
`timescale 1ns/1ns
`default_nettype none
module coa_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr_out,
  input wire logic addr_reg_space,
  input wire logic addr_bank,
  input wire logic addr_write,
  input wire logic addr_strobe,
  output logic [15:0] hits,
  output logic [9:0] last_loc
);
  logic [7:0] ram [256]; // data ram
  logic [7:0] regs [512]; // two banks of 256
  // log each access; a store leaves the hit count as a marker
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hits <= 16'h0000;
      last_loc <= 10'h000;
    end else if (addr_strobe) begin
      hits <= hits + 16'h0001;
      last_loc <= {addr_reg_space, addr_bank, addr_out};
      if (addr_write && addr_reg_space) begin
        regs[{addr_bank, addr_out}] <= hits[7:0];
      end else if (addr_write) begin
        ram[addr_out] <= hits[7:0];
      end
    end
  end
endmodule // coa_mem_model
`default_nettype wire

// ===== tb/cpu_operand_addressing_test.sv
// bench for the operand addressing block over ahb-lite.
// assumes zero wait states, one slave, memory model on the address side.
`timescale 1ns/1ns
`default_nettype none
module cpu_operand_addressing_test
  import coa_pkg::*;
();
  logic clk, rst, hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0] addr_out, pc_high_byte, pc_low_byte, exp_flags;
  logic addr_reg_space, addr_bank, addr_write, addr_strobe, bank_select_bit;
  logic [15:0] hits, exp_pc, exp_hits;
  logic [9:0] last_loc;
  int errors, total_checks;
  assign hready = hreadyout; // one slave: its ready is the bus ready
  coa_operand_addr DUT (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .addr_out(addr_out), .addr_reg_space(addr_reg_space),
    .addr_bank(addr_bank), .addr_write(addr_write),
    .addr_strobe(addr_strobe), .bank_select_bit(bank_select_bit),
    .pc_high_byte(pc_high_byte), .pc_low_byte(pc_low_byte));
  coa_mem_model MEM (.clk(clk), .rst(rst), .addr_out(addr_out),
    .addr_reg_space(addr_reg_space), .addr_bank(addr_bank),
    .addr_write(addr_write), .addr_strobe(addr_strobe), .hits(hits),
    .last_loc(last_loc));
  // 250 MHz core clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // verdict and end of run
  task test_done;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // one comparison
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // bounded wait for hready sampled high at a rising edge
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      errors++;
      $display("Error hready expected 1 seen %b", hready);
      test_done();
    end
  endtask
  // single word write: address phase, then data phase
  task ahb_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= 1'b1;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
  endtask
  // single word read; data taken at the data-phase edge
  task ahb_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= 1'b0;
    wait_rdy();
    htrans <= 2'b00;
    wait_rdy();
    d = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  // one decode: ports, result word, pc advance, memory side
  task dec(input logic [2:0] m, input logic rs, input logic [1:0] t,
           input logic ar, input logic [7:0] ea, input logic [1:0] src,
           input logic [1:0] sec);
    logic [1:0] len;
    logic vld, wr;
    logic [31:0] mk;
    len = (m == 3'h5 || m == 3'h6) ? 2'h3 : (m == 3'h7) ? 2'h0 : 2'h2;
    vld = (m != 3'h0 && m != 3'h7);
    wr = (m >= 3'h3 && m <= 3'h6);
    mk = vld ? 32'h0300_FFFF : 32'h0300_F900;
    ahb_wr(OFS_CTRL, {25'h0, ar, t, rs, m});
    exp_pc = exp_pc + {14'h0, len};
    @(negedge clk);
    chk("addr_strobe", {31'h0, vld}, {31'h0, addr_strobe});
    chk("hrdata_idle", 32'h0, hrdata);
    if (vld) begin
      exp_hits = exp_hits + 16'h0001;
      chk("addr_out", {24'h0, ea}, {24'h0, addr_out});
      chk("addr_kind", {29'h0, rs, exp_flags[4], wr},
          {29'h0, addr_reg_space, addr_bank, addr_write});
    end
    ahb_rd(OFS_RESULT, rd);
    chk("result", {6'h0, sec, 8'h00, src, len, wr, exp_flags[4], rs, vld,
        ea} & mk, rd & mk);
    ahb_rd(OFS_PC, rd);
    chk("pc", {16'h0, exp_pc}, rd);
    chk("pc_ports", {16'h0, exp_pc}, {16'h0, pc_high_byte, pc_low_byte});
    chk("mem_hits", {16'h0, exp_hits}, {16'h0, hits});
    if (vld) begin
      chk("mem_loc", {22'h0, rs, exp_flags[4], ea}, {22'h0, last_loc});
    end
  endtask
  // hang guard
  initial begin
    #200000;
    errors++;
    $display("Error run_time expected end seen timeout");
    test_done();
  end
  // main sequence
  initial begin
    errors = 0;
    total_checks = 0;
    exp_pc = 16'h0000;
    exp_hits = 16'h0000;
    exp_flags = FLAGS_RESET;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    ahb_rd(OFS_PC, rd);
    chk("pc_reset", 32'h0, rd);
    ahb_wr(OFS_PC, 32'h0000_ABCD);
    ahb_rd(OFS_PC, rd);
    chk("pc_ro", 32'h0, rd);
    ahb_rd(OFS_CORE, rd);
    chk("core_reset", {8'h00, FLAGS_RESET, 16'h0000}, rd);
    ahb_rd(8'h14, rd);
    chk("unmapped", 32'h0, rd);
    ahb_wr(OFS_OPND, 32'h0000_6620);
    ahb_wr(OFS_CORE, 32'h0010_F05A);
    exp_flags = 8'h10;
    @(negedge clk);
    chk("bank_bit", 32'h1, {31'h0, bank_select_bit});
    dec(3'h1, 1'b1, 2'h0, 1'b1, 8'h20, 2'h3, 2'h1);
    dec(3'h1, 1'b0, 2'h3, 1'b1, 8'h20, 2'h3, 2'h2);
    dec(3'h2, 1'b0, 2'h0, 1'b1, 8'h10, 2'h3, 2'h1);
    dec(3'h3, 1'b1, 2'h0, 1'b1, 8'h20, 2'h1, 2'h3);
    dec(3'h3, 1'b0, 2'h3, 1'b0, 8'h20, 2'h2, 2'h0);
    dec(3'h4, 1'b1, 2'h0, 1'b1, 8'h10, 2'h1, 2'h3);
    dec(3'h5, 1'b0, 2'h0, 1'b1, 8'h20, 2'h0, 2'h3);
    ahb_rd(OFS_RESULT, rd);
    chk("imm_dir", 32'h66, {24'h0, rd[23:16]});
    dec(3'h6, 1'b1, 2'h0, 1'b1, 8'h10, 2'h0, 2'h3);
    ahb_rd(OFS_RESULT, rd);
    chk("imm_idx", 32'h66, {24'h0, rd[23:16]});
    dec(3'h7, 1'b0, 2'h0, 1'b0, 8'h00, 2'h0, 2'h0);
    ahb_rd(OFS_CORE, rd);
    chk("acc_kept", 32'h5A, {24'h0, rd[7:0]});
    ahb_wr(OFS_CORE, 32'h0000_F05A);
    exp_flags = 8'h00;
    dec(3'h1, 1'b1, 2'h0, 1'b0, 8'h20, 2'h3, 2'h0);
    ahb_wr(OFS_OPND, 32'h0000_00FF);
    dec(3'h0, 1'b0, 2'h0, 1'b1, 8'h00, 2'h0, 2'h1);
    dec(3'h0, 1'b0, 2'h3, 1'b1, 8'h00, 2'h0, 2'h2);
    dec(3'h0, 1'b0, 2'h1, 1'b1, 8'h00, 2'h0, 2'h0);
    for (int t = 0; t < 4; t++) begin
      dec(3'h0, 1'b0, 2'(t), 1'b0, 8'h00, 2'h0, 2'h0);
      if (t == 1) begin
        exp_flags = 8'h1F;
      end
    end
    ahb_rd(OFS_CORE, rd);
    chk("imm_loads", 32'hFF1F_FFFF, rd);
    dec(3'h4, 1'b0, 2'h0, 1'b0, 8'hFE, 2'h1, 2'h0);
    // control and operand words read back as last written
    ahb_rd(OFS_CTRL, rd);
    chk("ctrl_rd", 32'h0000_0004, rd);
    ahb_rd(OFS_OPND, rd);
    chk("opnd_rd", 32'h0000_00FF, rd);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("pc_rerst", 32'h0, {16'h0, pc_high_byte, pc_low_byte});
    chk("bank_rerst", 32'h0, {31'h0, bank_select_bit});
    ahb_rd(OFS_CORE, rd);
    chk("core_rerst", {8'h00, FLAGS_RESET, 16'h0000}, rd);
    // reset leaves the reserved mode in the control word
    ahb_rd(OFS_CTRL, rd);
    chk("ctrl_rerst", 32'h0000_0007, rd);
    test_done();
  end
endmodule // cpu_operand_addressing_test
`default_nettype wire
